// ### logic/bit_pkg.sv
// bit_pkg: constants, field layouts and carrier types of the basic interval timer
// assumes a 40 MHz i_clk that also serves as the oscillator input of the prescaler
package bit_pkg;

	// apb address width and data width
	localparam int unsigned BIT_AW = 12;
	localparam int unsigned BIT_DW = 32;

	// register indices as printed, byte address is four times the index
	localparam logic [BIT_AW-1:0] BIT_CTL_INDEX = 12'h0f2;
	localparam logic [BIT_AW-1:0] BIT_CNT_INDEX = 12'h0f3;
	localparam logic [BIT_AW-1:0] BIT_CTL_ADDR  = {BIT_CTL_INDEX[BIT_AW-3:0], 2'h0};
	localparam logic [BIT_AW-1:0] BIT_CNT_ADDR  = {BIT_CNT_INDEX[BIT_AW-3:0], 2'h0};

	// control register field positions
	localparam int unsigned BIT_SEL_LSB  = 0;
	localparam int unsigned BIT_SEL_MSB  = 2;
	localparam int unsigned BIT_CLR_POS  = 3;
	localparam int unsigned BIT_WDM_POS  = 4;

	// control register reset value
	localparam logic [7:0] BIT_CTL_RESET = 8'h17;

	// counter and prescaler geometry
	localparam int unsigned BIT_CNT_W = 8;
	localparam int unsigned BIT_PRE_W = 10;
	localparam int unsigned BIT_PRE_BASE = 3;  // code 000 divides by 2**3
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_MAX  = 8'hff;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 8'h00;

	// prescaler division select, one code per doubling
	typedef enum logic [2:0] {
		BIT_DIV8    = 3'h0,
		BIT_DIV16   = 3'h1,
		BIT_DIV32   = 3'h2,
		BIT_DIV64   = 3'h3,
		BIT_DIV128  = 3'h4,
		BIT_DIV256  = 3'h5,
		BIT_DIV512  = 3'h6,
		BIT_DIV1024 = 3'h7
	} bit_div_e;

	// software visible control fields
	typedef struct packed {
		logic     watchdog_mode_select; // 1: watchdog, 0: plain 8-bit timer
		logic     counter_clear_bit;    // self clearing restart request
		bit_div_e prescale_select;      // division of the oscillator input
	} bit_ctl_s;

	// events leaving the counter
	typedef struct packed {
		logic ovf;   // one-cycle pulse on ff -> 00
		logic tick;  // one-cycle pulse on every count
	} bit_evt_s;

	// mask of prescaler bits that must all be one for a count pulse
	function automatic logic [BIT_PRE_W-1:0] bit_pre_mask(input bit_div_e sel);
		logic [BIT_PRE_W:0] m;
		m = ({{BIT_PRE_W{1'b0}}, 1'b1} << (BIT_PRE_BASE + 32'(sel)));
		return BIT_PRE_W'(m - 1'b1);
	endfunction

endpackage

// ### logic/bit_prescaler.sv
// bit_prescaler: free-running divider giving one count pulse per selected period
// assumes i_ce low means the peripheral clock is stopped
`timescale 1ns/10ps
`default_nettype none
module bit_prescaler (
	input  wire logic              i_clk,
	input  wire logic              i_srst,
	input  wire logic              i_ce,
	input  wire bit_pkg::bit_div_e i_sel,
	output logic                   o_pulse
);
	import bit_pkg::*;

	// whole state of the divider
	typedef struct packed {
		logic [BIT_PRE_W-1:0] div;    // running divider
		logic                 pulse;  // registered count pulse
	} bit_pre_s;

	bit_pre_s st;       // current state
	bit_pre_s next_st;  // next state

	// divider runs whenever i_ce is high, the select only picks which carry becomes the pulse
	always_comb begin
		next_st = st;
		next_st.div = st.div + 1'b1;
		// pulse when all selected low bits are ones, i.e. once per 8<<sel clocks
		next_st.pulse = ((st.div & bit_pre_mask(i_sel)) == bit_pre_mask(i_sel));
	end

	// freeze while the peripheral clock is stopped
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st <= '0;
		end else if (i_ce) begin
			st <= next_st;
		end
	end

	assign o_pulse = st.pulse;
endmodule
`default_nettype wire

// ### logic/bit_counter.sv
// bit_counter: 8-bit free-running interval counter with clear and wrap detection
// assumes i_tick is a one-cycle pulse from the prescaler
`timescale 1ns/10ps
`default_nettype none
module bit_counter (
	input  wire logic                          i_clk,
	input  wire logic                          i_srst,
	input  wire logic                          i_ce,
	input  wire logic                          i_tick,
	input  wire logic                          i_clear,
	output logic [bit_pkg::BIT_CNT_W-1:0]      o_count,
	output bit_pkg::bit_evt_s                  o_evt
);
	import bit_pkg::*;

	// whole state of the counter
	typedef struct packed {
		logic [BIT_CNT_W-1:0] cnt;  // interval count value
		bit_evt_s             evt;  // registered events
	} bit_cnt_s;

	bit_cnt_s st;       // current state
	bit_cnt_s next_st;  // next state

	// count, wrap and clear; no software path can halt it
	always_comb begin
		next_st = st;
		next_st.evt = '0;
		if (i_clear) begin
			// clear wins, a coincident wrap is dropped
			next_st.cnt = BIT_CNT_ZERO;
		end else if (i_tick) begin
			next_st.cnt = st.cnt + 1'b1;
			next_st.evt.tick = 1'b1;
			next_st.evt.ovf = (st.cnt == BIT_CNT_MAX);
		end
	end

	// freeze while the peripheral clock is stopped
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st <= '0;
		end else if (i_ce) begin
			st <= next_st;
		end
	end

	assign o_count = st.cnt;
	assign o_evt   = st.evt;
endmodule
`default_nettype wire

// ### logic/bit_top.sv
// bit_top: basic interval timer with its apb register slave
// assumes an apb3 master on i_clk and a clock enable that drops in stop mode
//
// Operation
// - eight-bit counter runs freely, never software-halted
// - counter advances once per prescaler count pulse
// - wrap from ff to 00 raises interrupt
// - writing clear bit zeroes counter, then resumes
// - clear bit drops by itself after one cycle
// - low three bits pick division 8 to 1024
// - mode bit: watchdog or plain 8-bit timer
// - counter wraps give the watchdog its time base
// - stopped peripheral clock freezes counter and prescaler
`timescale 1ns/10ps
`default_nettype none
module bit_top (
	input  wire logic                       i_clk,
	input  wire logic                       i_srst,
	input  wire logic                       i_clk_en,
	input  wire logic                       i_psel,
	input  wire logic                       i_penable,
	input  wire logic                       i_pwrite,
	input  wire logic [bit_pkg::BIT_AW-1:0] i_paddr,
	input  wire logic [bit_pkg::BIT_DW-1:0] i_pwdata,
	output logic [bit_pkg::BIT_DW-1:0]      o_prdata,
	output logic                            o_pready,
	output logic                            o_pslverr,
	output logic                            o_irq,
	output logic                            o_wdt_tick,
	output logic                            o_watchdog_mode
);
	import bit_pkg::*;

	// whole state of the top: bus answer and control register
	typedef struct packed {
		logic              pready;  // answer strobe of the access phase
		logic              pslverr; // unmapped address flag
		logic [BIT_DW-1:0] prdata;  // read data held for the access phase
		bit_ctl_s          ctl;     // control register fields
	} bit_top_s;

	bit_top_s st;       // current state
	bit_top_s next_st;  // next state

	// wires between the pieces
	logic                 pre_pulse;  // count pulse from the prescaler
	logic [BIT_CNT_W-1:0] count;      // live counter value
	bit_evt_s             evt;        // wrap and tick pulses

	// bus phase decode
	logic setup_ph;   // first cycle of a transfer
	logic access_ok;  // edge at which the transfer completes
	logic hit_ctl;    // control register selected
	logic hit_cnt;    // counter register selected

	// reads back the control register with the upper bits as zero
	function automatic logic [BIT_DW-1:0] ctl_word(input bit_ctl_s c);
		logic [BIT_DW-1:0] w;
		w = '0;
		w[BIT_WDM_POS] = c.watchdog_mode_select;
		w[BIT_CLR_POS] = c.counter_clear_bit;
		w[BIT_SEL_MSB:BIT_SEL_LSB] = c.prescale_select;
		return w;
	endfunction

	// prescaler: divides i_clk by the selected ratio
	bit_prescaler u_pre (
		.i_clk   (i_clk),
		.i_srst  (i_srst),
		.i_ce    (i_clk_en),
		.i_sel   (st.ctl.prescale_select),
		.o_pulse (pre_pulse)
	);

	// interval counter, cleared by the pending clear bit
	bit_counter u_cnt (
		.i_clk   (i_clk),
		.i_srst  (i_srst),
		.i_ce    (i_clk_en),
		.i_tick  (pre_pulse),
		.i_clear (st.ctl.counter_clear_bit),
		.o_count (count),
		.o_evt   (evt)
	);

	// address and phase decode
	always_comb begin
		setup_ph  = i_psel && !i_penable;
		access_ok = i_psel && i_penable && st.pready;
		hit_ctl   = (i_paddr == BIT_CTL_ADDR);
		hit_cnt   = (i_paddr == BIT_CNT_ADDR);
	end

	// next state: bus answer plus control register
	always_comb begin
		next_st = st;
		// the clear request lives exactly one cycle
		next_st.ctl.counter_clear_bit = 1'b0;
		if (setup_ph) begin
			// answer ready for the access phase, one wait-free cycle
			next_st.pready  = 1'b1;
			next_st.pslverr = !(hit_ctl || hit_cnt);
			if (hit_ctl) begin
				next_st.prdata = ctl_word(st.ctl);
			end else if (hit_cnt) begin
				// live count, upper bits read as zero
				next_st.prdata = {{(BIT_DW-BIT_CNT_W){1'b0}}, count};
			end else begin
				next_st.prdata = '0;
			end
		end else if (access_ok) begin
			// transfer ends here, drop the answer
			next_st.pready  = 1'b0;
			next_st.pslverr = 1'b0;
			next_st.prdata  = '0;
			if (i_pwrite && hit_ctl) begin
				// bits seven to five are not stored
				next_st.ctl.watchdog_mode_select = i_pwdata[BIT_WDM_POS];
				next_st.ctl.prescale_select =
					bit_div_e'(i_pwdata[BIT_SEL_MSB:BIT_SEL_LSB]);
				// a one starts a clear, a zero has no effect
				next_st.ctl.counter_clear_bit = i_pwdata[BIT_CLR_POS];
			end
			// writes to the counter register are ignored
		end else begin
			// idle or abandoned transfer
			next_st.pready  = 1'b0;
			next_st.pslverr = 1'b0;
		end
	end

	// single register stage; everything freezes while the clock enable is low
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st.pready  <= 1'b0;
			st.pslverr <= 1'b0;
			st.prdata  <= '0;
			st.ctl     <= bit_ctl_s'(BIT_CTL_RESET[BIT_WDM_POS:0]);
		end else if (i_clk_en) begin
			st <= next_st;
		end
	end

	// event outputs come straight from the counter's flops, the mode output from the control register
	assign o_irq           = evt.ovf;
	assign o_wdt_tick      = evt.ovf;
	assign o_watchdog_mode = st.ctl.watchdog_mode_select;

	// bus answer straight from the state register
	assign o_prdata  = st.prdata;
	assign o_pready  = st.pready;
	assign o_pslverr = st.pslverr;
endmodule
`default_nettype wire

// ### test/bit_top_asserts.sv
// bit_top_asserts: port-level checks of the interval timer
// assumes it is bound onto bit_top, one clock, synchronous reset
`timescale 1ns/10ps
`default_nettype none
module bit_top_asserts import bit_pkg::*; (
	input wire logic              i_clk,
	input wire logic              i_srst,
	input wire logic              i_clk_en,
	input wire logic              i_psel,
	input wire logic              i_penable,
	input wire logic              i_pwrite,
	input wire logic [BIT_AW-1:0] i_paddr,
	input wire logic [BIT_DW-1:0] i_pwdata,
	input wire logic [BIT_DW-1:0] o_prdata,
	input wire logic              o_pready,
	input wire logic              o_pslverr,
	input wire logic              o_irq,
	input wire logic              o_wdt_tick,
	input wire logic              o_watchdog_mode
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	// wrap is one cycle wide while running
	a_wrap_pulse: assert property (o_irq && i_clk_en |=> !o_irq)
		else $error("wrap pulse too long");
	// watchdog time base is the wrap itself
	a_tick_is_wrap: assert property (o_wdt_tick == o_irq)
		else $error("tick differs from wrap");
	// first edge out of reset shows watchdog mode and idle bus
	a_reset_state: assert property ($fell(i_srst) |-> o_watchdog_mode && !o_pready)
		else $error("bad state after reset");
	// no wait states: setup is answered at once
	a_ready_setup: assert property (i_clk_en && i_psel && !i_penable |=> o_pready)
		else $error("setup not answered");
	a_ready_single: assert property (i_clk_en && o_pready |=> !o_pready)
		else $error("ready held too long");
	// spare control bits read as zero
	a_spare_zero: assert property (o_pready && i_paddr == BIT_CTL_ADDR |-> o_prdata[31:5] == '0)
		else $error("spare bits not zero");
	// mode output follows a completed control write
	a_mode_write: assert property (i_clk_en && o_pready && i_pwrite && i_paddr == BIT_CTL_ADDR
		|=> o_watchdog_mode == $past(i_pwdata[BIT_WDM_POS]))
		else $error("mode not written");
	// refusal is only shown with the answer
	a_err_with_ready: assert property (o_pslverr |-> o_pready)
		else $error("error outside access phase");
	// read data bus is quiet between answers
	a_data_idle: assert property (!o_pready |-> o_prdata == '0)
		else $error("read data outside access phase");
	// stopped clock freezes the wrap and ready outputs
	a_stop_freeze: assert property (!i_clk_en |=> $stable(o_irq) && $stable(o_pready))
		else $error("state moved while stopped");
endmodule
`default_nettype wire

// ### test/tb_bit_top.sv
// tb_bit_top: self-checking apb bench for the interval timer
// assumes the bench alone drives every input of bit_top
`timescale 1ns/10ps
`default_nettype none
module tb_bit_top;
	import bit_pkg::*;
	logic              i_clk = 0;
	logic              i_srst = 1;
	logic              i_clk_en = 1;
	logic              i_psel = 0;
	logic              i_penable = 0;
	logic              i_pwrite = 0;
	logic [BIT_AW-1:0] i_paddr = '0;
	logic [BIT_DW-1:0] i_pwdata = '0;
	logic [BIT_DW-1:0] o_prdata, rd, c1;
	logic              o_pready, o_pslverr, o_irq, o_wdt_tick, o_watchdog_mode;
	logic [31:0]       seed = 32'h8bb409c7;
	int                n_mismatch = 0;
	int                samples_checked = 0;
	int                n_irq = 0;  // wrap pulses seen so far
	logic              er;         // error flag taken with the answer
	bit_top u_dut (
		.i_clk           (i_clk),
		.i_srst          (i_srst),
		.i_clk_en        (i_clk_en),
		.i_psel          (i_psel),
		.i_penable       (i_penable),
		.i_pwrite        (i_pwrite),
		.i_paddr         (i_paddr),
		.i_pwdata        (i_pwdata),
		.o_prdata        (o_prdata),
		.o_pready        (o_pready),
		.o_pslverr       (o_pslverr),
		.o_irq           (o_irq),
		.o_wdt_tick      (o_wdt_tick),
		.o_watchdog_mode (o_watchdog_mode)
	);
	// counts wrap pulses, so that a dropped wrap can be told from a late one
	always @(posedge i_clk) begin
		if (o_irq === 1'b1) begin
			n_irq <= n_irq + 1;
		end
	end
	// 25 ns clock
	initial begin
		forever #12.5 i_clk = ~i_clk;
	end
	// fibonacci step, taps 32 22 2 1
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// control readback: spare bits and clear bit gone
	function automatic logic [31:0] ctl_exp(input logic [31:0] v);
		return {27'h0, v[4], 1'b0, v[2:0]};
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// one apb transfer, held until pready is sampled
	task automatic apb(input logic w, input logic [BIT_AW-1:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_psel <= 1;
		i_penable <= 0;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1;
		// no cycle count assumed, only the watchdog ends this wait
		do begin
			@(posedge i_clk);
		end while (o_pready !== 1'b1);
		rd = o_prdata;
		er = o_pslverr;
		i_psel <= 0;
		i_penable <= 0;
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// hang guard, about three times the expected run
	initial begin
		#1000000;
		n_mismatch++;
		give_verdict();
	end
	initial begin
		repeat (2) @(posedge i_clk);
		i_srst <= 0;
		apb(0, BIT_CTL_ADDR, 32'h0);
		chk("ctl reset", 32'h17, rd);
		chk("mode reset", 32'h1, o_watchdog_mode);
		apb(0, 12'h3d0, 32'h0);
		chk("unmapped err", 32'h1, er);
		chk("unmapped data", 32'h0, rd);
		// random images: spare bits drop, clear bit self-clears
		for (int k = 0; k < 6; k++) begin
			seed = lfsr(lfsr(lfsr(seed)));
			apb(1, BIT_CTL_ADDR, seed);
			apb(0, BIT_CTL_ADDR, 32'h0);
			chk("ctl", ctl_exp(seed), rd);
			chk("mode", seed[4], o_watchdog_mode);
		end
		$display("end register test");
		// reads exactly five periods apart see five counts
		for (int k = 0; k < 8; k++) begin
			apb(1, BIT_CTL_ADDR, k);
			apb(0, BIT_CNT_ADDR, 32'h0);
			c1 = rd;
			repeat ((8 << k) * 5 - 3) @(posedge i_clk);
			apb(0, BIT_CNT_ADDR, 32'h0);
			chk("count step", 32'h5, 8'(rd - c1));
		end
		$display("end rate test");
		// back to /8: 50 stopped cycles out of 114 leave 64, eight counts
		apb(1, BIT_CTL_ADDR, 32'h0);
		apb(0, BIT_CNT_ADDR, 32'h0);
		c1 = rd;
		repeat (30) @(posedge i_clk);
		i_clk_en <= 0;
		repeat (50) @(posedge i_clk);
		i_clk_en <= 1;
		repeat (31) @(posedge i_clk);
		apb(0, BIT_CNT_ADDR, 32'h0);
		chk("frozen count", 32'h8, 8'(rd - c1));
		$display("end stop test");
		apb(1, BIT_CTL_ADDR, 32'h8);
		apb(0, BIT_CNT_ADDR, 32'h0);
		chk("cleared", 32'h0, rd);
		// 256 counts of 8 clocks after the clear, first tick 1 to 8 clocks late
		for (c1 = 0; c1 < 3000 && o_irq !== 1'b1; c1++) @(negedge i_clk);
		chk("wrap time", 32'h1, c1 >= 2040 && c1 <= 2047);
		chk("tick", 32'h1, o_wdt_tick);
		apb(0, BIT_CNT_ADDR, 32'h0);
		chk("after wrap", 32'h0, rd);
		$display("end wrap test");
		// clear lands on the edge of the next wrap, 2048 clocks on
		c1 = n_irq;
		repeat (2041) @(posedge i_clk);
		apb(1, BIT_CTL_ADDR, 32'h8);
		apb(0, BIT_CNT_ADDR, 32'h0);
		chk("clear wins", 32'h0, rd);
		chk("no wrap irq", c1, n_irq);
		$display("end clash test");
		i_srst <= 1;
		repeat (2) @(posedge i_clk);
		i_srst <= 0;
		apb(0, BIT_CTL_ADDR, 32'h0);
		chk("ctl rereset", 32'h17, rd);
		chk("mode rereset", 32'h1, o_watchdog_mode);
		apb(0, BIT_CNT_ADDR, 32'h0);
		chk("count rereset", 32'h0, rd);
		$display("end reset test");
		give_verdict();
	end
endmodule
bind bit_top bit_top_asserts u_chk (
	.i_clk           (i_clk),
	.i_srst          (i_srst),
	.i_clk_en        (i_clk_en),
	.i_psel          (i_psel),
	.i_penable       (i_penable),
	.i_pwrite        (i_pwrite),
	.i_paddr         (i_paddr),
	.i_pwdata        (i_pwdata),
	.o_prdata        (o_prdata),
	.o_pready        (o_pready),
	.o_pslverr       (o_pslverr),
	.o_irq           (o_irq),
	.o_wdt_tick      (o_wdt_tick),
	.o_watchdog_mode (o_watchdog_mode)
);
`default_nettype wire
